// ==== i2c_slave_cfg.svh ====
// Register offsets, field positions, reset values and codes of the I2C slave interface.
// Assumes a 32-bit Avalon-MM register port with one aligned word per register.
`ifndef I2C_SLAVE_CFG_SVH
`define I2C_SLAVE_CFG_SVH

`define OFS_SERIAL_MODE_CONTROL 5'h00
`define OFS_BUS_STATUS_CONTROL 5'h04
`define OFS_OWN_SLAVE_ADDRESS 5'h08
`define OFS_SHIFT_DATA 5'h0C

`define MODE_ENABLE_BIT 0
`define MODE_FUNC_LSB 5
`define FUNC_I2C_SLAVE 3'h6

`define STAT_RX_ACK_BIT 0
`define STAT_READ_REQ_BIT 1
`define STAT_ACK_TO_SEND_BIT 2
`define STAT_TX_SELECT_BIT 3
`define STAT_BUSY_BIT 4
`define STAT_ADDR_MATCH_BIT 5
`define STAT_BYTE_DONE_BIT 6

`define RESET_BYTE 8'h00
`define BITS_PER_BYTE 4'h8

`endif

// ==== i2c_slave_pkg.sv ====
// Types shared by the I2C slave interface.
// Takes no constants from i2c_slave_cfg.svh; the state codes are written here.
package i2c_slave_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACK_ADDR = 3'h3,
        ST_HOLD = 3'h2,
        ST_XFER = 3'h6,
        ST_ACK = 3'h7,
        ST_WAIT_STOP = 3'h5
    } slave_state_t;

    typedef struct packed {
        logic busy;
        logic addr_match;
        logic byte_done;
        logic rx_ack;
        logic read_req;
    } flags_t;

endpackage

// ==== i2c_slave_interface.sv ====
// Byte-oriented I2C slave controller with an Avalon-MM register port.
// Assumes external pull-ups on both bus wires and a pad mux outside driven by pins_active.
`include "i2c_slave_cfg.svh"

module i2c_slave_interface #(
    parameter bit SIM_FUNCTION = 1'b1,
    parameter int DEBOUNCE = 0,
    parameter bit ALT_CLOCK = 1'b0
) (
    input wire logic clk,
    input wire logic clk_alt,
    input wire logic rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic pins_active,
    output logic irq_pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock source and register port.

    // The choice is fixed at build time, so this is a static selection, not a glitchy mux.
    logic core_clk;
    assign core_clk = ALT_CLOCK ? clk_alt : clk;

    function automatic logic [2:0] reg_index(input logic [4:0] a);
        case (a)
            `OFS_SERIAL_MODE_CONTROL: reg_index = 3'h0;
            `OFS_BUS_STATUS_CONTROL: reg_index = 3'h1;
            `OFS_OWN_SLAVE_ADDRESS: reg_index = 3'h2;
            `OFS_SHIFT_DATA: reg_index = 3'h3;
            default: reg_index = 3'h4;
        endcase
    endfunction

    logic ack_q;
    logic wr_commit;
    logic rd_commit;
    logic [2:0] sel;
    logic [7:0] mode_q;
    logic ack_to_send_q;
    logic tx_select_q;
    logic [7:1] own_addr_q;
    logic [7:0] data_q;
    i2c_slave_pkg::flags_t flags_q;
    i2c_slave_pkg::slave_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] addr_sr_q;
    logic enabled;

    assign sel = reg_index(address);
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_commit = write & ack_q & byteenable[0];
    assign rd_commit = read & ack_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if ((read & ~ack_q) == 1'b1) begin
            case (sel)
                3'h0: readdata <= {24'h00_0000, mode_q};
                3'h1: readdata <= {25'h000_0000, flags_q.byte_done, flags_q.addr_match, flags_q.busy,
                                   tx_select_q, ack_to_send_q, flags_q.read_req, flags_q.rx_ack};
                3'h2: readdata <= {24'h00_0000, own_addr_q, 1'b0};
                3'h3: readdata <= {24'h00_0000, data_q};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Registers reset to defined values; software must still set them after enabling.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= `RESET_BYTE;
            ack_to_send_q <= 1'b0;
            tx_select_q <= 1'b0;
            own_addr_q <= 7'h00;
        end else if (wr_commit) begin
            if (sel == 3'h0) begin
                mode_q <= {writedata[7:5], 4'h0, writedata[`MODE_ENABLE_BIT]};
            end
            if (sel == 3'h1) begin
                ack_to_send_q <= writedata[`STAT_ACK_TO_SEND_BIT];
                tx_select_q <= writedata[`STAT_TX_SELECT_BIT];
            end
            if (sel == 3'h2) begin
                own_addr_q <= writedata[7:1];
            end
        end
    end

    assign enabled = SIM_FUNCTION && mode_q[`MODE_ENABLE_BIT] &&
                     (mode_q[7:5] == `FUNC_I2C_SLAVE);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, clock debounce and bus condition detection.

    localparam logic [1:0] DB = 2'(DEBOUNCE);
    logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
    logic scl_f_q, scl_p_q, sda_p_q;
    logic [1:0] db_cnt_q;
    logic [2:0] sda_dly_q;
    logic sda_f;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_dly_q <= 3'h7;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_dly_q <= {sda_dly_q[1:0], sda_s2_q};
        end
    end

    // A clock change is accepted only after it has stood for DB extra cycles; data is
    // delayed by the same amount so that a data change after a clock fall is not
    // mistaken for START or STOP.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_f_q <= 1'b1;
            db_cnt_q <= 2'h0;
        end else if (scl_s2_q == scl_f_q) begin
            db_cnt_q <= 2'h0;
        end else if (db_cnt_q == DB) begin
            scl_f_q <= scl_s2_q;
            db_cnt_q <= 2'h0;
        end else begin
            db_cnt_q <= db_cnt_q + 2'h1;
        end
    end

    assign sda_f = sda_dly_q[DB];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f;
        end
    end

    assign scl_rise = scl_f_q & ~scl_p_q;
    assign scl_fall = ~scl_f_q & scl_p_q;
    assign start_det = enabled & scl_f_q & scl_p_q & sda_p_q & ~sda_f;
    assign stop_det = enabled & scl_f_q & scl_p_q & ~sda_p_q & sda_f;

    ////////////////////////////////////////////////////////////////////////////////
    // Slave sequencer: address, acknowledge, clock hold, data byte, acknowledge.

    logic addr_hit, release_hold, addr_done, byte_end;
    assign addr_hit = (addr_sr_q[7:1] == own_addr_q);
    assign addr_done = (state_q == i2c_slave_pkg::ST_ADDR) & scl_fall & (bit_cnt_q == `BITS_PER_BYTE);
    assign byte_end = (state_q == i2c_slave_pkg::ST_XFER) & scl_rise & (bit_cnt_q == 4'h7);
    // Transmit is released by loading the next byte, receive by a dummy read.
    assign release_hold = (state_q == i2c_slave_pkg::ST_HOLD) & (sel == 3'h3) &
                          (tx_select_q ? wr_commit : rd_commit);

    always_ff @(posedge core_clk) begin
        if (rst || !enabled) begin
            state_q <= i2c_slave_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
        end else if (stop_det) begin
            state_q <= i2c_slave_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
        end else if (start_det) begin
            state_q <= i2c_slave_pkg::ST_ADDR;
            bit_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                i2c_slave_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (addr_done) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= addr_hit ? i2c_slave_pkg::ST_ACK_ADDR : i2c_slave_pkg::ST_WAIT_STOP;
                    end
                end
                i2c_slave_pkg::ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        state_q <= i2c_slave_pkg::ST_HOLD;
                    end
                end
                i2c_slave_pkg::ST_HOLD: begin
                    if (release_hold) begin
                        state_q <= i2c_slave_pkg::ST_XFER;
                    end
                end
                i2c_slave_pkg::ST_XFER: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= i2c_slave_pkg::ST_ACK;
                    end
                end
                i2c_slave_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state_q <= (tx_select_q && flags_q.rx_ack) ? i2c_slave_pkg::ST_WAIT_STOP
                                                                   : i2c_slave_pkg::ST_HOLD;
                    end
                end
                i2c_slave_pkg::ST_WAIT_STOP: state_q <= i2c_slave_pkg::ST_WAIT_STOP;
                default: state_q <= i2c_slave_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_sr_q <= 8'h00;
        end else if (state_q == i2c_slave_pkg::ST_ADDR && scl_rise) begin
            addr_sr_q <= {addr_sr_q[6:0], sda_f};
        end
    end

    // Software writes and bus shifting share one register; a software write wins a collision.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_q <= `RESET_BYTE;
        end else if (wr_commit && sel == 3'h3) begin
            data_q <= writedata[7:0];
        end else if (state_q == i2c_slave_pkg::ST_XFER) begin
            if (!tx_select_q && scl_rise && bit_cnt_q < `BITS_PER_BYTE) begin
                data_q <= {data_q[6:0], sda_f};
            end else if (tx_select_q && scl_fall && bit_cnt_q != 4'h0 && bit_cnt_q != `BITS_PER_BYTE) begin
                data_q <= {data_q[6:0], 1'b1};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !enabled) begin
            flags_q <= '0;
        end else begin
            if (start_det) begin
                flags_q.busy <= 1'b1;
            end else if (stop_det) begin
                flags_q.busy <= 1'b0;
            end
            if (addr_done) begin
                flags_q.addr_match <= addr_hit;
                flags_q.read_req <= addr_sr_q[0];
            end else if (release_hold) begin
                flags_q.addr_match <= 1'b0;
            end
            if (byte_end) begin
                flags_q.byte_done <= 1'b1;
            end else if (release_hold) begin
                flags_q.byte_done <= 1'b0;
            end
            if (state_q == i2c_slave_pkg::ST_ACK && tx_select_q && scl_rise) begin
                flags_q.rx_ack <= sda_f;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain pin drive and interrupt.

    always_ff @(posedge core_clk) begin
        if (rst || !enabled) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            pins_active <= 1'b0;
            irq_pulse <= 1'b0;
        end else begin
            pins_active <= 1'b1;
            scl_oe <= (state_q == i2c_slave_pkg::ST_HOLD);
            sda_oe <= (state_q == i2c_slave_pkg::ST_ACK_ADDR) |
                      (state_q == i2c_slave_pkg::ST_ACK && !tx_select_q && !ack_to_send_q) |
                      (state_q == i2c_slave_pkg::ST_XFER && tx_select_q && !data_q[7]);
            irq_pulse <= (addr_done & addr_hit) | byte_end;
        end
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_stop_seen;
        stop_det ##1 1'b1;
    endsequence

    pins_idle_off_a: assert property (!enabled |=> !scl_oe && !sda_oe && !pins_active)
        else $error("pins driven while interface disabled");
    func_code_a: assert property (enabled |-> mode_q[7:5] == 3'h6)
        else $error("enabled with wrong function code");
    busy_start_stop_a: assert property ((start_det |=> flags_q.busy) and (s_stop_seen |-> !flags_q.busy))
        else $error("busy flag does not follow start and stop");
    stop_idle_a: assert property (stop_det |=> state_q == i2c_slave_pkg::ST_IDLE)
        else $error("stop did not return to idle");
    addr_ack_drive_a: assert property (addr_done && addr_hit |=> state_q == i2c_slave_pkg::ST_ACK_ADDR ##1 sda_oe)
        else $error("no acknowledge after matching address");
    addr_mismatch_a: assert property (addr_done && !addr_hit |=> !flags_q.addr_match && !irq_pulse)
        else $error("mismatch flagged as match");
    hold_clock_a: assert property (state_q == i2c_slave_pkg::ST_HOLD && !release_hold |=> scl_oe)
        else $error("clock not held while waiting for software");
    rx_ack_drive_a: assert property (state_q == i2c_slave_pkg::ST_ACK && !tx_select_q
                                     |=> sda_oe == !$past(ack_to_send_q))
        else $error("wrong acknowledge level in receive");
    nack_release_a: assert property (state_q == i2c_slave_pkg::ST_ACK && tx_select_q && flags_q.rx_ack
                                     && scl_fall && !stop_det && !start_det |=> ##1 !sda_oe)
        else $error("data line kept after refused acknowledge");
    byte_done_irq_a: assert property (byte_end |=> flags_q.byte_done && irq_pulse)
        else $error("byte completion not flagged");

endmodule // i2c_slave_interface

// ==== i2c_master_model.sv ====
// Behavioural I2C bus master that drives both wires through open-drain pulls.
// Assumes pull-ups outside: a wire reads high unless some party pulls it low.
module i2c_master_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    int timeouts = 0;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The slave may stretch the low phase, so the rise is awaited, not assumed.
    // After one timeout each later wait ends after a single cycle, so a stuck slave cannot drag the run on.
    task automatic release_scl();
        int n;
        n = 0;
        scl_pull <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (scl !== 1'b1 && n < 1000 && timeouts == 0);
        if (scl !== 1'b1) begin
            timeouts++;
        end
    endtask

    // Data changes early in the low phase and is sampled late in the high phase.
    task automatic clock_bit(input logic b, output logic v);
        sda_pull <= ~b;
        repeat (HALF) @(posedge clk);
        release_scl();
        repeat (HALF) @(posedge clk);
        v = sda;
        scl_pull <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic start();
        sda_pull <= 1'b1;
        repeat (HALF) @(posedge clk);
        scl_pull <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic stop();
        sda_pull <= 1'b1;
        repeat (HALF) @(posedge clk);
        release_scl();
        repeat (HALF) @(posedge clk);
        sda_pull <= 1'b0;
        repeat (HALF) @(posedge clk);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], v);
        end
        clock_bit(1'b1, ack);
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(nack, v);
    endtask
endmodule // i2c_master_model

// ==== tb_top.sv ====
// Self-checking bench of the I2C slave interface with a behavioural bus master.
// Assumes the register map of i2c_slave_cfg.svh; register accesses wait on waitrequest, not a fixed count.
`include "i2c_slave_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, read, write, waitrequest, scl_o, scl_oe, sda_o, sda_oe;
    logic pins_active, irq_pulse, m_scl, m_sda, ack;
    logic [4:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic [7:0] byte_in;
    wire scl_w, sda_w;
    int error_cnt = 0;
    int checks = 0;
    int irq_cnt = 0;
    int irq0;

    assign scl_w = (scl_oe | m_scl) ? 1'b0 : 1'b1;
    assign sda_w = (sda_oe | m_sda) ? 1'b0 : 1'b1;

    i2c_slave_interface dut (.clk(clk), .clk_alt(1'b0), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .pins_active(pins_active), .irq_pulse(irq_pulse));
    i2c_master_model mst (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (irq_pulse === 1'b1) begin
            irq_cnt++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        error_cnt += mst.timeouts;
        $display("TB: errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request stands until waitrequest is sampled low at a rising edge; read data is taken at that edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        byteenable <= be;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 100) begin
            error_cnt++;
            test_done();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_reset_access();
        logic [4:0] ofs [4] = '{`OFS_SERIAL_MODE_CONTROL, `OFS_BUS_STATUS_CONTROL, `OFS_OWN_SLAVE_ADDRESS,
                                `OFS_SHIFT_DATA};
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 8'h00, 4'h1, rd);
            chk(rd, 32'h0000_0000);
        end
        chk({30'h0, scl_o, sda_o}, 32'h0000_0000);
        bus(1'b1, `OFS_OWN_SLAVE_ADDRESS, 8'hB5, 4'h0, rd);
        bus(1'b0, `OFS_OWN_SLAVE_ADDRESS, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_0000);
        bus(1'b1, `OFS_OWN_SLAVE_ADDRESS, 8'hB5, 4'h1, rd);
        bus(1'b0, `OFS_OWN_SLAVE_ADDRESS, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_00B4);
        bus(1'b1, 5'h10, 8'hFF, 4'h1, rd);
        bus(1'b0, 5'h10, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_0000);
    endtask

    // Enable low with the right code, then enable high with an SPI code: neither may answer.
    task automatic disabled_modes();
        logic [7:0] cfg [2] = '{8'hC0, 8'h01};
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, `OFS_SERIAL_MODE_CONTROL, cfg[i], 4'h1, rd);
            repeat (4) @(posedge clk);
            chk({31'h0, pins_active}, 32'h0000_0000);
            mst.start();
            mst.write_byte(8'hB4, ack);
            chk({31'h0, ack}, 32'h0000_0001);
            mst.stop();
            bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
            chk(rd, 32'h0000_0000);
        end
    endtask

    task automatic slave_receive();
        bus(1'b1, `OFS_SERIAL_MODE_CONTROL, {`FUNC_I2C_SLAVE, 4'h0, 1'b1}, 4'h1, rd);
        repeat (4) @(posedge clk);
        chk({31'h0, pins_active}, 32'h0000_0001);
        irq0 = irq_cnt;
        mst.start();
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_0010);
        mst.write_byte(8'hB4, ack);
        chk({31'h0, ack}, 32'h0000_0000);
        repeat (10) @(posedge clk);
        chk(irq_cnt - irq0, 32'h0000_0001);
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_0030);
        chk({31'h0, scl_oe}, 32'h0000_0001);
        fork
            mst.write_byte(8'h1E, ack);
            begin
                bus(1'b0, `OFS_SHIFT_DATA, 8'h00, 4'h1, rd);
                repeat (40) @(posedge clk);
                bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
                chk(rd & 32'h0000_0060, 32'h0000_0000);
            end
        join
        chk({31'h0, ack}, 32'h0000_0000);
        repeat (10) @(posedge clk);
        chk(irq_cnt - irq0, 32'h0000_0002);
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_0050);
        bus(1'b1, `OFS_BUS_STATUS_CONTROL, 8'h04, 4'h1, rd);
        bus(1'b0, `OFS_SHIFT_DATA, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_001E);
        mst.write_byte(8'hC5, ack);
        chk({31'h0, ack}, 32'h0000_0001);
        fork
            mst.stop();
            bus(1'b0, `OFS_SHIFT_DATA, 8'h00, 4'h1, rd);
        join
        chk(rd, 32'h0000_00C5);
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd, 32'h0000_0004);
    endtask

    task automatic slave_transmit();
        mst.start();
        mst.write_byte(8'hB5, ack);
        chk({31'h0, ack}, 32'h0000_0000);
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
        bus(1'b1, `OFS_BUS_STATUS_CONTROL, 8'h08, 4'h1, rd);
        fork
            mst.read_byte(1'b0, byte_in);
            bus(1'b1, `OFS_SHIFT_DATA, 8'h96, 4'h1, rd);
        join
        chk({24'h00_0000, byte_in}, 32'h0000_0096);
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd & 32'h0000_0041, 32'h0000_0040);
        fork
            mst.read_byte(1'b1, byte_in);
            bus(1'b1, `OFS_SHIFT_DATA, 8'h0D, 4'h1, rd);
        join
        chk({24'h00_0000, byte_in}, 32'h0000_000D);
        repeat (10) @(posedge clk);
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd & 32'h0000_0001, 32'h0000_0001);
        chk({30'h0, scl_oe, sda_oe}, 32'h0000_0000);
        mst.stop();
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd & 32'h0000_0010, 32'h0000_0000);
    endtask

    task automatic address_mismatch();
        irq0 = irq_cnt;
        mst.start();
        mst.write_byte(8'h66, ack);
        chk({31'h0, ack}, 32'h0000_0001);
        bus(1'b0, `OFS_BUS_STATUS_CONTROL, 8'h00, 4'h1, rd);
        chk(rd & 32'h0000_0020, 32'h0000_0000);
        chk(irq_cnt - irq0, 32'h0000_0000);
        mst.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        reg_reset_access();
        disabled_modes();
        slave_receive();
        slave_transmit();
        address_mismatch();
        test_done();
    end
endmodule // tb_top
